// ===== afmc_consts.svh
// Constants for the analog front-end configuration and monitor block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef AFMC_CONSTS_SVH
`define AFMC_CONSTS_SVH

// -------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// -------------------------------------------------------------
`define AFMC_OFS_FRONT 8'h00
`define AFMC_OFS_REF 8'h01
`define AFMC_OFS_BURN 8'h02
`define AFMC_OFS_EXC_ROUTE 8'h03
`define AFMC_OFS_EXC_MAG 8'h04
`define AFMC_OFS_STATUS 8'h05

// -------------------------------------------------------------
// Field positions
// -------------------------------------------------------------
`define AFMC_FRONT_BYPASS 0
`define AFMC_FRONT_VREF_EN 1
`define AFMC_FRONT_SHIFT 2
`define AFMC_REF_NEG_LSB 0
`define AFMC_REF_POS_LSB 2
`define AFMC_BURN_LVL_LSB 0
`define AFMC_BURN_PULLUP 3
`define AFMC_EXC_A_LSB 0
`define AFMC_EXC_B_LSB 4
`define AFMC_STAT_AMP_HIGH 0
`define AFMC_STAT_AMP_LOW 1
`define AFMC_STAT_LOW_VREF 2

// -------------------------------------------------------------
// Reset values and fixed codes
// -------------------------------------------------------------
`define AFMC_RST_FRONT 8'h00
`define AFMC_RST_REF 8'h05
`define AFMC_RST_BURN 8'h00
`define AFMC_RST_EXC_ROUTE 8'h00
`define AFMC_RST_EXC_MAG 8'h00
`define AFMC_BURN_MAX_CODE 3'h4
`define AFMC_LARGE_VARIANT 1'b1

`endif

// ===== afmc_frontend.sv
// Configuration and status logic of a converter analog front end.
// Assumes single clock mclk, synchronous reset, comparators asynchronous.
//
// Overview of operation
// - High overload flag when amp output near top
// - Low overload flag when amp output near bottom
// - Overload flags read-only, clear at next conversion
// - Ignore overload comparators while input mux switches
// - Bypass routes inputs straight to precharge buffers
// - Amplifier powered down during bypass
// - Two independent two-bit reference select fields
// - Positive and negative reference source choices
// - Code 00b selects internal reference
// - Code 01b selects supply, reset default
// - 10b inputs 0/1, 11b inputs 2/3
// - Internal reference enable bit, off at reset
// - Low-reference flag, clears at next conversion
// - Low-reference detector follows selected reference
// - Level shift closes mid-supply switch to common input
// - Burn-out current: off and four magnitudes
// - Burn-out at mux output, pull-up or pull-down
// - Pull-up: source to positive, sink to negative
// - Two excitation sources with route and magnitude
// - Both excitation sources may share one input
//
// The register addresses and the strobed register port were left to the implementer.
`default_nettype none
`include "afmc_consts.svh"

module afmc_frontend
    import afmc_pkg::*;
(
    // Clock, reset
    input wire logic mclk, // Converter clock, 40 MHz
    input wire logic rst, // Synchronous reset, active high
    // Register port
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, one cycle after strobe
    // Comparators, timing
    input wire logic amp_high_cmp, // Async comparator: output above upper limit
    input wire logic amp_low_cmp, // Async comparator: output below lower limit
    input wire logic vref_low_cmp, // Async comparator: reference below 0.4 V
    input wire logic mux_switching, // Input mux transition in progress
    input wire logic conv_start, // Pulse at start of each conversion cycle
    // Analog controls
    output logic amp_power_en, // Amplifier powered
    output logic amp_bypass_route, // Inputs go straight to precharge buffers
    output logic [3:0] pos_vref_select, // One-hot: internal, supply, input 0, input 2
    output logic [3:0] neg_vref_select, // One-hot: internal, supply, input 1, input 3
    output logic internal_vref_enable, // Internal 2.5 V reference on
    output logic mid_supply_shift, // Switch to common analog input closed
    // Burn-out, excitation
    output logic [2:0] burn_level, // Burn-out magnitude code
    output logic burn_src_to_pos, // Sourcing current on positive channel
    output logic burn_sink_to_neg, // Sinking current on negative channel
    output logic burn_src_to_neg, // Sourcing current on negative channel
    output logic burn_sink_to_pos, // Sinking current on positive channel
    output logic [3:0] excite_a_route, // Source A input pin index
    output logic [3:0] excite_a_magnitude, // Source A magnitude, 0 is off
    output logic [3:0] excite_b_route, // Source B input pin index
    output logic [3:0] excite_b_magnitude, // Source B magnitude, 0 is off
    output logic excite_shared, // Both sources drive one input
    // Status
    output logic amp_high_overload_flag, // Status: high overload
    output logic amp_low_overload_flag, // Status: low overload
    output logic low_vref_flag // Status: low reference
);

    // -------------------------------------------------------------
    // Helper functions
    // -------------------------------------------------------------

    // One-hot reference decode, shared by both multiplexers
    function automatic logic [3:0] vsel_decode(input logic [1:0] code);
        logic [3:0] hot;
        hot = 4'h0;
        case (code)
            AFMC_VREF_INTERNAL: hot = 4'h1; // Internal positive or negative
            AFMC_VREF_SUPPLY: hot = 4'h2; // Supply rail
            AFMC_VREF_EXT_A: hot = 4'h4; // Inputs 0 and 1
            AFMC_VREF_EXT_B: hot = `AFMC_LARGE_VARIANT ? 4'h8 : 4'h2; // Small part falls back to supply
            default: hot = 4'h2;
        endcase
        return hot;
    endfunction

    // Out-of-range burn-out codes read as off
    // So an undefined code never drives a current
    function automatic logic [2:0] burn_clip(input logic [2:0] code);
        return (code > `AFMC_BURN_MAX_CODE) ? AFMC_BURN_OFF : code;
    endfunction

    // -------------------------------------------------------------
    // Comparator synchronisers
    // -------------------------------------------------------------
    logic [2:0] cmp_raw; // Asynchronous comparator levels
    logic [2:0] cmp_meta_r; // First stage, read only by second stage
    logic [2:0] cmp_sync_r; // Second stage, safe to use

    // Bit 0 amp high, bit 1 amp low, bit 2 low ref
    assign cmp_raw = {vref_low_cmp, amp_low_cmp, amp_high_cmp};

    // Two flops per comparator; the analog side has no relation to mclk
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (rst) begin
                    cmp_meta_r[gi] <= 1'b0;
                    cmp_sync_r[gi] <= 1'b0;
                end else begin
                    cmp_meta_r[gi] <= cmp_raw[gi];
                    cmp_sync_r[gi] <= cmp_meta_r[gi];
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------
    logic [7:0] front_r; // Bypass, reference enable, level shift
    logic [7:0] ref_r; // Reference selects
    logic [7:0] burn_r; // Burn-out level and polarity
    logic [7:0] exc_route_r; // Excitation routes
    logic [7:0] exc_mag_r; // Excitation magnitudes
    logic [7:0] rdata_r; // Read data holder
    logic wr_front; // Decoded write enables
    logic wr_ref;
    logic wr_burn;
    logic wr_route;
    logic wr_mag;

    // Write decode; status is read-only
    assign wr_front = reg_wr && (reg_addr == `AFMC_OFS_FRONT);
    assign wr_ref = reg_wr && (reg_addr == `AFMC_OFS_REF);
    assign wr_burn = reg_wr && (reg_addr == `AFMC_OFS_BURN);
    assign wr_route = reg_wr && (reg_addr == `AFMC_OFS_EXC_ROUTE);
    assign wr_mag = reg_wr && (reg_addr == `AFMC_OFS_EXC_MAG);

    // Only meaningful bits are kept so reserved bits read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            front_r <= `AFMC_RST_FRONT;
            ref_r <= `AFMC_RST_REF;
            burn_r <= `AFMC_RST_BURN;
            exc_route_r <= `AFMC_RST_EXC_ROUTE;
            exc_mag_r <= `AFMC_RST_EXC_MAG;
        end else begin
            if (wr_front) begin
                front_r <= {5'h00, reg_wdata[2:0]};
            end
            if (wr_ref) begin
                ref_r <= {4'h0, reg_wdata[3:0]};
            end
            if (wr_burn) begin
                burn_r <= {4'h0, reg_wdata[3:0]};
            end
            if (wr_route) begin
                exc_route_r <= reg_wdata;
            end
            if (wr_mag) begin
                exc_mag_r <= reg_wdata;
            end
        end
    end

    // -------------------------------------------------------------
    // Status flags
    // -------------------------------------------------------------
    logic amp_high_r; // Sticky high overload
    logic amp_low_r; // Sticky low overload
    logic low_vref_r; // Sticky low reference
    logic amp_high_set; // Qualified set terms
    logic amp_low_set;
    logic low_vref_set;

    // Next states
    logic amp_high_nxt;
    logic amp_low_nxt;
    logic low_vref_nxt;

    // Overload comparators blanked during mux switching to avoid false trips
    assign amp_high_set = cmp_sync_r[0] && !mux_switching;
    assign amp_low_set = cmp_sync_r[1] && !mux_switching;
    // Comparator sits after the reference mux, so it tracks the selection
    assign low_vref_set = cmp_sync_r[2];

    // Flag holds until a conversion start with condition gone; set wins
    assign amp_high_nxt = amp_high_set || (amp_high_r && !conv_start);
    assign amp_low_nxt = amp_low_set || (amp_low_r && !conv_start);
    assign low_vref_nxt = low_vref_set || (low_vref_r && !conv_start);

    // Flags update only from synchronised comparator levels
    always_ff @(posedge mclk) begin
        if (rst) begin
            amp_high_r <= 1'b0;
            amp_low_r <= 1'b0;
            low_vref_r <= 1'b0;
        end else begin
            amp_high_r <= amp_high_nxt;
            amp_low_r <= amp_low_nxt;
            low_vref_r <= low_vref_nxt;
        end
    end

    // -------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------
    logic [7:0] status_byte; // Read-only flag byte
    logic [7:0] rd_mux; // Selected read value

    // Reads never clear flags
    assign status_byte = {5'h00, low_vref_r, amp_low_r, amp_high_r};

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            `AFMC_OFS_FRONT: rd_mux = front_r;
            `AFMC_OFS_REF: rd_mux = ref_r;
            `AFMC_OFS_BURN: rd_mux = burn_r;
            `AFMC_OFS_EXC_ROUTE: rd_mux = exc_route_r;
            `AFMC_OFS_EXC_MAG: rd_mux = exc_mag_r;
            `AFMC_OFS_STATUS: rd_mux = status_byte;
            default: rd_mux = 8'h00; // Unmapped reads zero
        endcase
    end

    // Read data valid only in the cycle after the strobe
    // Zero between reads keeps the bus quiet
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // -------------------------------------------------------------
    // Analog control decode
    // -------------------------------------------------------------
    logic bypass_sel; // Bypass requested
    logic [2:0] burn_lvl_dec; // Legal burn-out code
    logic burn_on; // Any burn-out current flowing
    logic burn_pullup; // Pull-up polarity
    logic [3:0] pos_hot; // Positive mux one-hot
    logic [3:0] neg_hot; // Negative mux one-hot
    logic a_on; // Source A active
    logic b_on; // Source B active
    logic shared_dec; // Both sources on the same pin

    assign bypass_sel = front_r[`AFMC_FRONT_BYPASS];
    assign pos_hot = vsel_decode(ref_r[`AFMC_REF_POS_LSB +: 2]);
    assign neg_hot = vsel_decode(ref_r[`AFMC_REF_NEG_LSB +: 2]);
    assign burn_lvl_dec = burn_clip(burn_r[`AFMC_BURN_LVL_LSB +: 3]);
    // Burn-out controls
    assign burn_on = (burn_lvl_dec != AFMC_BURN_OFF);
    assign burn_pullup = burn_r[`AFMC_BURN_PULLUP];
    // A zero magnitude means off
    assign a_on = (exc_mag_r[`AFMC_EXC_A_LSB +: 4] != 4'h0);
    assign b_on = (exc_mag_r[`AFMC_EXC_B_LSB +: 4] != 4'h0);
    // Sharing is legal; the pin then carries the sum of both currents
    assign shared_dec = a_on && b_on &&
        (exc_route_r[`AFMC_EXC_A_LSB +: 4] == exc_route_r[`AFMC_EXC_B_LSB +: 4]);

    // -------------------------------------------------------------
    // Registered analog controls
    // -------------------------------------------------------------
    // Amp and reference
    logic amp_power_r;
    logic bypass_route_r;
    logic [3:0] pos_sel_r;
    logic [3:0] neg_sel_r;
    logic vref_en_r;
    logic shift_r;

    // Burn-out
    logic [2:0] burn_lvl_r;
    logic src_pos_r;
    logic sink_neg_r;
    logic src_neg_r;
    logic sink_pos_r;

    // Excitation
    logic [3:0] a_route_r;
    logic [3:0] a_mag_r;
    logic [3:0] b_route_r;
    logic [3:0] b_mag_r;
    logic shared_r;

    // One flop stage keeps analog switches glitch-free during decode
    always_ff @(posedge mclk) begin
        if (rst) begin
            // Amp on, supply reference
            amp_power_r <= 1'b1;
            bypass_route_r <= 1'b0;
            pos_sel_r <= 4'h2;
            neg_sel_r <= 4'h2;
            vref_en_r <= 1'b0;
            shift_r <= 1'b0;
            // Burn-out and excitation off
            burn_lvl_r <= 3'h0;
            src_pos_r <= 1'b0;
            sink_neg_r <= 1'b0;
            src_neg_r <= 1'b0;
            sink_pos_r <= 1'b0;
            a_route_r <= 4'h0;
            a_mag_r <= 4'h0;
            b_route_r <= 4'h0;
            b_mag_r <= 4'h0;
            shared_r <= 1'b0;
        end else begin
            amp_power_r <= !bypass_sel;
            bypass_route_r <= bypass_sel;
            pos_sel_r <= pos_hot;
            neg_sel_r <= neg_hot;
            vref_en_r <= front_r[`AFMC_FRONT_VREF_EN];
            shift_r <= front_r[`AFMC_FRONT_SHIFT];
            burn_lvl_r <= burn_lvl_dec;
            // Burn-out polarity
            src_pos_r <= burn_on && burn_pullup;
            sink_neg_r <= burn_on && burn_pullup;
            src_neg_r <= burn_on && !burn_pullup;
            sink_pos_r <= burn_on && !burn_pullup;
            // Excitation
            a_route_r <= exc_route_r[`AFMC_EXC_A_LSB +: 4];
            a_mag_r <= exc_mag_r[`AFMC_EXC_A_LSB +: 4];
            b_route_r <= exc_route_r[`AFMC_EXC_B_LSB +: 4];
            b_mag_r <= exc_mag_r[`AFMC_EXC_B_LSB +: 4];
            shared_r <= shared_dec;
        end
    end

    // -------------------------------------------------------------
    // Output drive
    // -------------------------------------------------------------
    // Register port
    assign reg_rdata = rdata_r;

    // Analog controls
    assign amp_power_en = amp_power_r;
    assign amp_bypass_route = bypass_route_r;
    assign pos_vref_select = pos_sel_r;
    assign neg_vref_select = neg_sel_r;
    assign internal_vref_enable = vref_en_r;
    assign mid_supply_shift = shift_r;
    assign burn_level = burn_lvl_r;
    assign burn_src_to_pos = src_pos_r;
    assign burn_sink_to_neg = sink_neg_r;
    assign burn_src_to_neg = src_neg_r;
    assign burn_sink_to_pos = sink_pos_r;
    assign excite_a_route = a_route_r;
    assign excite_a_magnitude = a_mag_r;
    assign excite_b_route = b_route_r;
    assign excite_b_magnitude = b_mag_r;
    assign excite_shared = shared_r;

    // Status flags
    assign amp_high_overload_flag = amp_high_r;
    assign amp_low_overload_flag = amp_low_r;
    assign low_vref_flag = low_vref_r;

endmodule // afmc_frontend

`default_nettype wire

// ===== afmc_frontend_asserts.sv
// Checker: flag timing, select decode and register port.
// Assumes a bind onto afmc_frontend; sees its ports only.
`default_nettype none
`include "afmc_consts.svh"
module afmc_frontend_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic amp_high_cmp,
    input wire logic amp_low_cmp,
    input wire logic vref_low_cmp,
    input wire logic mux_switching,
    input wire logic conv_start,
    input wire logic amp_power_en,
    input wire logic amp_bypass_route,
    input wire logic [3:0] pos_vref_select,
    input wire logic [3:0] neg_vref_select,
    input wire logic [2:0] burn_level,
    input wire logic burn_src_to_pos,
    input wire logic burn_sink_to_neg,
    input wire logic burn_src_to_neg,
    input wire logic burn_sink_to_pos,
    input wire logic amp_high_overload_flag,
    input wire logic amp_low_overload_flag,
    input wire logic low_vref_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------
    // Properties
    // ------
    // One domain, so clock and reset are given once
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Two sync stages, then set unless blanked
    a_high_flag_set: assert property (amp_high_cmp ##2 !mux_switching |=> amp_high_overload_flag)
        else $error("high flag not set");
    a_low_flag_set: assert property (amp_low_cmp ##2 !mux_switching |=> amp_low_overload_flag)
        else $error("low flag not set");
    // Reference monitor is never blanked
    a_vref_flag_set: assert property (vref_low_cmp |=> ##2 low_vref_flag)
        else $error("low reference flag not set");
    a_blank_holds_off: assert property (!amp_high_overload_flag && mux_switching |=> !amp_high_overload_flag)
        else $error("flag set while blanked");
    a_flag_sticky: assert property (amp_high_overload_flag && !conv_start |=> amp_high_overload_flag)
        else $error("flag dropped without conversion");
    // Synced term is the comparator two edges back
    a_flag_clears: assert property (!amp_high_cmp ##2 conv_start |=> !amp_high_overload_flag)
        else $error("flag kept after conversion");
    a_vref_clears: assert property (!vref_low_cmp ##2 conv_start |=> !low_vref_flag)
        else $error("low reference flag kept");
    a_bypass_follows: assert property (reg_wr && reg_addr == `AFMC_OFS_FRONT |=> ##1
        amp_bypass_route == $past(reg_wdata[0], 2) && amp_power_en == !amp_bypass_route)
        else $error("bypass or power wrong");
    a_ref_write: assert property (reg_wr && reg_addr == `AFMC_OFS_REF |=> ##1
        pos_vref_select == 4'h1 << $past(reg_wdata[3:2], 2) && neg_vref_select == 4'h1 << $past(reg_wdata[1:0], 2))
        else $error("reference select wrong");
    a_burn_polarity: assert property (burn_src_to_pos == burn_sink_to_neg
        && burn_src_to_neg == burn_sink_to_pos && !(burn_src_to_pos && burn_src_to_neg)
        && (burn_level != 3'h0) == (burn_src_to_pos || burn_src_to_neg))
        else $error("burn routing wrong");
    a_status_read: assert property (reg_rd && reg_addr == `AFMC_OFS_STATUS |=> reg_rdata ==
        {5'h0, $past(low_vref_flag), $past(amp_low_overload_flag), $past(amp_high_overload_flag)})
        else $error("status read wrong");
    c_conv_on_flag: cover property (amp_high_overload_flag && conv_start);
    c_blanked: cover property (mux_switching && amp_high_cmp);
    c_burn_on: cover property (burn_src_to_pos);
endmodule // afmc_frontend_asserts

bind afmc_frontend afmc_frontend_asserts afmc_frontend_asserts_i (
    .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .amp_high_cmp,
    .amp_low_cmp, .vref_low_cmp, .mux_switching, .conv_start, .amp_power_en,
    .amp_bypass_route, .pos_vref_select, .neg_vref_select, .burn_level, .burn_src_to_pos,
    .burn_sink_to_neg, .burn_src_to_neg, .burn_sink_to_pos, .amp_high_overload_flag,
    .amp_low_overload_flag, .low_vref_flag
);
`default_nettype wire

// ===== afmc_frontend_test.sv
// Self-checking bench: registers, decode and status flags.
// Assumes afmc_consts.svh on the include path.
`default_nettype none
`include "afmc_consts.svh"
module afmc_frontend_test;
    timeunit 1ns;
    timeprecision 100ps;
    // ------
    // Signals and design
    // ------
    logic mclk, rst, reg_wr, reg_rd, conv_start, mux_switching; // Controls
    logic amp_high_cmp, amp_low_cmp, vref_low_cmp; // Comparator levels
    logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register port
    logic amp_power_en, amp_bypass_route, internal_vref_enable, mid_supply_shift;
    logic [3:0] pos_vref_select, neg_vref_select; // One-hot selects
    logic [2:0] burn_level, lvl; // Burn code, seen and expected
    logic burn_src_to_pos, burn_sink_to_neg, burn_src_to_neg, burn_sink_to_pos, on;
    logic [3:0] excite_a_route, excite_a_magnitude, excite_b_route, excite_b_magnitude;
    logic excite_shared, amp_high_overload_flag, amp_low_overload_flag, low_vref_flag;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h921b8f72; // Fixed seed keeps runs repeatable
    logic [31:0] r; // Current random word

    afmc_frontend afmc_frontend_i (
        .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .amp_high_cmp,
        .amp_low_cmp, .vref_low_cmp, .mux_switching, .conv_start, .amp_power_en,
        .amp_bypass_route, .pos_vref_select, .neg_vref_select, .internal_vref_enable,
        .mid_supply_shift, .burn_level, .burn_src_to_pos, .burn_sink_to_neg, .burn_src_to_neg,
        .burn_sink_to_pos, .excite_a_route, .excite_a_magnitude, .excite_b_route,
        .excite_b_magnitude, .excite_shared, .amp_high_overload_flag, .amp_low_overload_flag,
        .low_vref_flag
    );

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ------
    // Helpers
    // ------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [3:0] hot(input logic [1:0] c);
        return 4'h1 << c;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Write, then an idle cycle; returns just after derived outputs update
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
        @(posedge mclk);
    endtask
    task automatic fl(input logic [7:0] e);
        #1;
        chk("flags", e, {5'h0, low_vref_flag, amp_low_overload_flag, amp_high_overload_flag});
        @(posedge mclk);
    endtask
    task automatic conv();
        conv_start <= 1'b1;
        @(posedge mclk);
        conv_start <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic final_report();
        $display("checked %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        cyc(5000);
        num_errors++;
        $display("unexpected run length: expected end, seen timeout");
        final_report();
    end

    // ------
    // Main sequence
    // ------
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, conv_start, mux_switching} = 4'h0;
        {amp_high_cmp, amp_low_cmp, vref_low_cmp} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cyc(6);
        rst <= 1'b0;
        cyc(1);
        #1;
        chk("selects", 8'h22, {pos_vref_select, neg_vref_select});
        chk("front", 8'h01, {mid_supply_shift, internal_vref_enable, amp_bypass_route, amp_power_en});
        @(posedge mclk);
        for (int i = 0; i < 6; i++) rdc(i[7:0], (i == 1) ? 8'h05 : 8'h00, "reset value");
        rdc(8'h3c, 8'h00, "unmapped");
        // Every select code on both sides, reserved bits random
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            wr(`AFMC_OFS_REF, {r[7:4], i[3:0]});
            chk("selects", {hot(i[3:2]), hot(i[1:0])}, {pos_vref_select, neg_vref_select});
            @(posedge mclk);
            rdc(`AFMC_OFS_REF, {4'h0, i[3:0]}, "ref reg");
        end
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            wr(`AFMC_OFS_FRONT, {r[7:3], i[2:0]});
            chk("front", {4'h0, i[2:1], i[0], ~i[0]},
                {mid_supply_shift, internal_vref_enable, amp_bypass_route, amp_power_en});
            @(posedge mclk);
            rdc(`AFMC_OFS_FRONT, {5'h0, i[2:0]}, "front reg");
        end
        // All level codes, undefined ones too, in both polarities
        for (int i = 0; i < 16; i++) begin
            wr(`AFMC_OFS_BURN, {4'h0, i[3:0]});
            lvl = (i[2:0] > 3'h4) ? 3'h0 : i[2:0];
            on = (lvl != 3'h0);
            chk("burn", {1'b0, lvl, on & i[3], on & i[3], on & ~i[3], on & ~i[3]},
                {1'b0, burn_level, burn_src_to_pos, burn_sink_to_neg, burn_src_to_neg, burn_sink_to_pos});
            @(posedge mclk);
        end
        // Reference on for the sources; shift on, then settle
        wr(`AFMC_OFS_FRONT, 8'h06);
        cyc(16);
        // First two passes share one pin; second has source B off
        for (int k = 0; k < 10; k++) begin
            r = rnd();
            if (k < 2) r[8:4] = {1'b1, r[3:0]};
            if (k == 1) r[15:12] = 4'h0;
            wr(`AFMC_OFS_EXC_ROUTE, r[7:0]);
            @(posedge mclk);
            wr(`AFMC_OFS_EXC_MAG, r[15:8]);
            chk("routes", r[7:0], {excite_b_route, excite_a_route});
            chk("mags", r[15:8], {excite_b_magnitude, excite_a_magnitude});
            chk("shared", {7'h0, r[15:12] != 0 && r[11:8] != 0 && r[7:4] == r[3:0]}, {7'h0, excite_shared});
            @(posedge mclk);
            rdc(`AFMC_OFS_EXC_MAG, r[15:8], "mag reg");
        end
        wr(`AFMC_OFS_STATUS, 8'hff);
        @(posedge mclk);
        rdc(`AFMC_OFS_STATUS, 8'h00, "status");
        amp_high_cmp <= 1'b1;
        cyc(5);
        fl(8'h01);
        rdc(`AFMC_OFS_STATUS, 8'h01, "status");
        // Conversion while sync stages still hold the overload
        amp_high_cmp <= 1'b0;
        conv();
        cyc(4);
        fl(8'h01);
        conv();
        fl(8'h00);
        mux_switching <= 1'b1;
        amp_high_cmp <= 1'b1;
        amp_low_cmp <= 1'b1;
        cyc(6);
        fl(8'h00);
        mux_switching <= 1'b0;
        cyc(4);
        fl(8'h03);
        amp_high_cmp <= 1'b0;
        amp_low_cmp <= 1'b0;
        mux_switching <= 1'b1;
        vref_low_cmp <= 1'b1;
        cyc(5);
        fl(8'h07);
        vref_low_cmp <= 1'b0;
        cyc(4);
        conv();
        fl(8'h00);
        mux_switching <= 1'b0;
        final_report();
    end
endmodule // afmc_frontend_test
`default_nettype wire

// ===== afmc_pkg.sv
// Types used by the front-end configuration block; its bench does not import them.
// Assumes afmc_consts.svh is on the include path.
`default_nettype none

package afmc_pkg;
    `include "afmc_consts.svh"

    // Reference multiplexer select codes
    typedef enum logic [1:0] {
        AFMC_VREF_INTERNAL = 2'h0,
        AFMC_VREF_SUPPLY = 2'h1,
        AFMC_VREF_EXT_A = 2'h2,
        AFMC_VREF_EXT_B = 2'h3
    } afmc_vsel_t;

    // Burn-out current level codes
    typedef enum logic [2:0] {
        AFMC_BURN_OFF = 3'h0,
        AFMC_BURN_50NA = 3'h1,
        AFMC_BURN_200NA = 3'h2,
        AFMC_BURN_1UA = 3'h3,
        AFMC_BURN_10UA = 3'h4
    } afmc_burn_t;
endpackage : afmc_pkg

`default_nettype wire
